// ==== rtl/pll_ctl_pkg.sv ====
// Purpose: Shared constants for the PLL control block
// Assumes: aclk at 25 MHz stands in for the PLL clock
// Notes:   Register index is scaled by four for AXI

package pll_ctl_pkg;
  // ----------------------------------------
  // Clock figures
  // ----------------------------------------
  localparam int unsigned XTAL_HZ        = 32768;
  localparam int unsigned PLL_MULT       = 384;
  localparam int unsigned PLL_HZ         = XTAL_HZ * PLL_MULT;
  localparam int unsigned FREE_RUN_KHZ   = 12580;
  localparam int unsigned FREE_RUN_TOLPC = 20;
  localparam int unsigned ACLK_PERIOD_NS = 40;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned DIV_W   = 3;
  localparam int unsigned CNT_W   = 7;
  localparam int unsigned TIMER_W = 16;

  // ----------------------------------------
  // Control register layout
  // ----------------------------------------
  localparam int unsigned OSC_HALT_BIT = 7;
  localparam int unsigned LOCK_BIT     = 6;
  localparam int unsigned RSVD_BIT     = 5;
  localparam int unsigned LATCH_BIT    = 4;
  localparam int unsigned FAST_BIT     = 3;
  localparam int unsigned CD_LSB       = 0;

  localparam logic [7:0]       CTRL_RESET = 8'h03;
  localparam logic [DIV_W-1:0] CD_RESET   = CTRL_RESET[2:0];
  localparam logic [DIV_W-1:0] FAST_DIV   = 3'h0;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [9:0]        CTRL_INDEX = 10'h0d7;
  localparam logic [ADDR_W-1:0] CTRL_ADDR  = {CTRL_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] TIMER_ADDR = 12'h000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_TIMER
  } reg_sel_e;
endpackage

// ==== rtl/clk_sel_if.sv ====
// Purpose: Divider request and core enable between top and generator
// Assumes: Single aclk domain
// Notes:   No clocking block

`timescale 1ns/100ps
`default_nettype none

interface clk_sel_if;
  import pll_ctl_pkg::*;
  logic [DIV_W-1:0] divider;
  logic             fast_en;
  logic             in_service;
  logic             core_en;
  logic [DIV_W-1:0] cur_div;

  modport ctl (output divider, fast_en, in_service, input core_en, cur_div);
  modport gen (input divider, fast_en, in_service, output core_en, cur_div);
endinterface

`default_nettype wire

// ==== rtl/core_clock_gen.sv ====
// Purpose: Core clock enable from the PLL clock by a binary divider
// Assumes: Divider 0..7 means divide by 1..128
// Notes:   Divisor changes only at a pulse boundary

`timescale 1ns/100ps
`default_nettype none

module core_clock_gen
  import pll_ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  clk_sel_if.gen   sel
);
  logic [CNT_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cur_div_reg;
  logic             core_en_reg;
  logic [DIV_W-1:0] req_div;
  logic [CNT_W-1:0] terminal;

  always_comb begin
    req_div  = (sel.fast_en && sel.in_service) ? FAST_DIV : sel.divider;
    terminal = CNT_W'((32'd1 << cur_div_reg) - 32'd1);
  end

  // boundary switch
  // Taking the new divisor only at a pulse keeps every period whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg     <= '0;
      cur_div_reg <= CD_RESET;
      core_en_reg <= 1'b0;
    end else if (cnt_reg == terminal) begin
      cnt_reg     <= '0;
      cur_div_reg <= req_div;
      core_en_reg <= 1'b1;
    end else begin
      cnt_reg     <= cnt_reg + 7'h01;
      core_en_reg <= 1'b0;
    end
  end

  assign sel.core_en = core_en_reg;
  assign sel.cur_div = cur_div_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_fast_entry: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(sel.in_service && sel.fast_en) |-> ##[1:130] (cur_div_reg == FAST_DIV))
    else $error("fast clock not reached after interrupt entry");

  a_irq_return: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($fell(sel.in_service) && $stable(sel.divider))
      |-> ##[1:130] (cur_div_reg == sel.divider))
    else $error("divider rate not restored after interrupt return");

  a_no_boost: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!$past(sel.fast_en) && core_en_reg) |-> (cur_div_reg == $past(sel.divider)))
    else $error("divisor boosted with fast response off");

  a_div_eight: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (core_en_reg && cur_div_reg == CD_RESET && req_div == CD_RESET)
      |=> !core_en_reg [*7] ##1 core_en_reg)
    else $error("divide by eight period wrong");

  a_glitch_free: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(cur_div_reg) |-> core_en_reg)
    else $error("divisor changed inside a period");
endmodule

`default_nettype wire

// ==== rtl/pll_clock_status_control.sv ====
// Purpose: PLL control register, oscillator halt, lock flag, fast irq clock
// Assumes: All inputs synchronous to aclk; xtal_tick is one pulse per crystal cycle
// Notes:   AXI4-Lite slave, one write and one read at a time
//
// Summary of operation
// - Halt bit set stops crystal oscillator in power-down; clear keeps it running.
// - Running oscillator keeps interval timer counting through power-down.
// - Lock flag is read-only; writes to its bit change nothing.
// - Lock flag set while the PLL tracks the crystal.
// - Lock flag cleared while PLL does not track the crystal.
// - Unlocked PLL free-runs near 12.58 MHz, plus or minus 20 percent.
// - Latched access bit returns pin level caught at reset.
// - Fast bit set runs interrupt service at highest core clock.
// - Interrupt return restores the divider-selected core clock.
// - Fast bit clear services interrupts at divider-selected clock.
// - PLL clock is 384 times the crystal, 12.582912 MHz.
// - Core clock is PLL clock over power of two, default eight.
// - Control register reads 03H after power-on.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.

`timescale 1ns/100ps
`default_nettype none

module pll_clock_status_control
  import pll_ctl_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                power_down,
  input  wire logic                xtal_tick,
  input  wire logic                pll_tracking,
  input  wire logic                external_access_pin,
  input  wire logic                irq_in_service,
  output logic                     crystal_osc_running,
  output logic                     pll_free_run,
  output logic                     core_clk_en,
  output logic [TIMER_W-1:0]       interval_timer
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic                awready_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [1:0]          rresp_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic                aw_got_reg;
  logic                w_got_reg;
  logic [ADDR_W-1:0]   waddr_reg;
  logic [7:0]          wbyte_reg;
  logic                wlane_reg;

  logic                aw_fire;
  logic                w_fire;
  logic                ar_fire;
  logic                wr_do;
  logic                aw_got_next;
  logic                w_got_next;
  logic                bvalid_next;
  logic                rvalid_next;
  reg_sel_e            wr_sel;
  reg_sel_e            rd_sel;

  logic                osc_halt_reg;
  logic                fast_irq_reg;
  logic [DIV_W-1:0]    cd_reg;
  logic                lock_reg;
  logic                latched_ext_reg;
  logic                latch_done_reg;
  logic                osc_run_reg;
  logic                free_run_reg;
  logic [TIMER_W-1:0]  timer_reg;
  logic                osc_on;
  logic [7:0]          ctrl_byte;

  clk_sel_if sel_if ();

  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
    case (a)
      CTRL_ADDR:  decode = SEL_CTRL;
      TIMER_ADDR: decode = SEL_TIMER;
      default:    decode = SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always_comb begin
    aw_fire     = awvalid && awready_reg;
    w_fire      = wvalid && wready_reg;
    ar_fire     = arvalid && arready_reg;
    wr_do       = aw_got_reg && w_got_reg && !bvalid_reg;
    aw_got_next = wr_do ? 1'b0 : (aw_got_reg || aw_fire);
    w_got_next  = wr_do ? 1'b0 : (w_got_reg || w_fire);
    bvalid_next = wr_do || (bvalid_reg && !bready);
    rvalid_next = ar_fire || (rvalid_reg && !rready);
    wr_sel      = decode(waddr_reg);
    rd_sel      = decode(araddr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      waddr_reg   <= '0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      awready_reg <= !aw_got_next && !bvalid_next;
      wready_reg  <= !w_got_next && !bvalid_next;
      if (aw_fire) begin
        waddr_reg <= awaddr;
      end
      if (w_fire) begin
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
    end
  end

  // Timer is read-only, so a write there is refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else begin
      bvalid_reg <= bvalid_next;
      if (wr_do) begin
        bresp_reg <= (wr_sel == SEL_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end else begin
      rvalid_reg  <= rvalid_next;
      arready_reg <= !rvalid_next;
      if (ar_fire) begin
        case (rd_sel)
          SEL_CTRL: begin
            rdata_reg <= {24'h000000, ctrl_byte};
            rresp_reg <= RESP_OKAY;
          end
          SEL_TIMER: begin
            rdata_reg <= {16'h0000, timer_reg};
            rresp_reg <= RESP_OKAY;
          end
          default: begin
            rdata_reg <= '0;
            rresp_reg <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[OSC_HALT_BIT] = osc_halt_reg;
    ctrl_byte[LOCK_BIT] = lock_reg;
    ctrl_byte[RSVD_BIT] = 1'b0;
    ctrl_byte[LATCH_BIT] = latched_ext_reg;
    ctrl_byte[FAST_BIT] = fast_irq_reg;
    ctrl_byte[CD_LSB +: DIV_W] = cd_reg;
  end

  // power-on value
  // Only halt, fast and divider bits are stored from a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_halt_reg <= CTRL_RESET[OSC_HALT_BIT];
      fast_irq_reg <= CTRL_RESET[FAST_BIT];
      cd_reg       <= CD_RESET;
    end else if (wr_do && wr_sel == SEL_CTRL && wlane_reg) begin
      osc_halt_reg <= wbyte_reg[OSC_HALT_BIT];
      fast_irq_reg <= wbyte_reg[FAST_BIT];
      cd_reg       <= wbyte_reg[CD_LSB +: DIV_W];
    end
  end

  // lock tracking
  // Unlocked means the PLL is free-running at a loose rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_reg     <= CTRL_RESET[LOCK_BIT];
      free_run_reg <= !CTRL_RESET[LOCK_BIT];
    end else begin
      lock_reg     <= pll_tracking;
      free_run_reg <= !pll_tracking;
    end
  end

  // latch access pin
  // Caught once after reset release, never from the reset itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_ext_reg <= CTRL_RESET[LATCH_BIT];
      latch_done_reg  <= 1'b0;
    end else if (!latch_done_reg) begin
      latched_ext_reg <= external_access_pin;
      latch_done_reg  <= 1'b1;
    end
  end

  // ----------------------------------------
  // Oscillator and interval timer
  // ----------------------------------------
  // oscillator halt
  assign osc_on = !(power_down && osc_halt_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_run_reg <= 1'b1;
    end else begin
      osc_run_reg <= osc_on;
    end
  end

  // timer in power-down
  // Ticks while halted are lost, as the crystal is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reg <= TIMER_RESET;
    end else if (xtal_tick && osc_on) begin
      timer_reg <= timer_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Core clock
  // ----------------------------------------
  assign sel_if.divider    = cd_reg;
  assign sel_if.fast_en    = fast_irq_reg;
  assign sel_if.in_service = irq_in_service;

  core_clock_gen u_core_clock_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (sel_if.gen)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready             = awready_reg;
  assign wready              = wready_reg;
  assign bvalid              = bvalid_reg;
  assign bresp               = bresp_reg;
  assign arready             = arready_reg;
  assign rvalid              = rvalid_reg;
  assign rresp               = rresp_reg;
  assign rdata               = rdata_reg;
  assign crystal_osc_running = osc_run_reg;
  assign pll_free_run        = free_run_reg;
  assign core_clk_en         = sel_if.core_en;
  assign interval_timer      = timer_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_osc_halt_pd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    power_down |=> (osc_run_reg == !$past(osc_halt_reg)))
    else $error("oscillator state wrong in power-down");

  a_timer_pd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (power_down && !osc_halt_reg && xtal_tick)
      |=> (timer_reg == $past(timer_reg) + 16'h0001))
    else $error("interval timer stalled in power-down");

  a_lock_ro: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_sel == SEL_CTRL && pll_tracking == lock_reg)
      |=> $stable(lock_reg))
    else $error("write changed lock flag");

  a_lock_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pll_tracking [*2] |-> (lock_reg && ctrl_byte[LOCK_BIT]))
    else $error("lock flag not set while tracking");

  a_lock_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !pll_tracking |=> (!lock_reg && pll_free_run))
    else $error("lock flag not cleared while unlocked");

  a_free_run_lock: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pll_free_run != lock_reg)
    else $error("free-run state disagrees with lock flag");

  a_latch_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    latch_done_reg |=> (latched_ext_reg == $past(latched_ext_reg)))
    else $error("latched access bit moved with the pin");

  a_latch_catch: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(latch_done_reg) |-> (latched_ext_reg == $past(external_access_pin)))
    else $error("access pin not latched after reset");

  a_reset_value: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (ctrl_byte == CTRL_RESET))
    else $error("control register reset value wrong");

  a_rsvd_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_fire && rd_sel == SEL_CTRL) |=> (rdata_reg[RSVD_BIT] == 1'b0))
    else $error("reserved bit read nonzero");

  a_bvalid_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bvalid_reg && !bready) |=> (bvalid_reg && $stable(bresp_reg)))
    else $error("write response dropped early");
endmodule

`default_nettype wire

// ==== tb/tb_pll_clock_status_control.sv ====
// Purpose: Self-checking bench for the PLL control block
// Assumes: AXI4-Lite master tasks; bench drives every port itself
// Notes:   Protection inputs held at zero; they carry no function

`timescale 1ns/100ps
`default_nettype none

module tb_pll_clock_status_control;
  import pll_ctl_pkg::*;

  logic              aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              power_down, xtal_tick, pll_tracking, external_access_pin, irq_in_service;
  logic              crystal_osc_running, pll_free_run, core_clk_en;
  logic [TIMER_W-1:0] interval_timer;
  int                n_fail, compares, cycles;
  logic [31:0]       rd;
  logic [1:0]        rs;

  pll_clock_status_control dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .power_down(power_down), .xtal_tick(xtal_tick), .pll_tracking(pll_tracking),
    .external_access_pin(external_access_pin), .irq_in_service(irq_in_service),
    .crystal_osc_running(crystal_osc_running), .pll_free_run(pll_free_run),
    .core_clk_en(core_clk_en), .interval_timer(interval_timer)
  );

  // ----------------------------------------
  // Clock, watchdog, reporting
  // ----------------------------------------
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // Whole run needs well under two thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Bus and pin helpers
  // ----------------------------------------
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      xtal_tick <= 1'b1;
      @(posedge aclk);
      xtal_tick <= 1'b0;
    end
  endtask

  // Gap after two pulses, so a pending divisor has been taken
  task automatic meas(output int p);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(posedge aclk);
        p = p + 1;
      end while (core_clk_en !== 1'b1 && p < 400);
    end
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    int p;
    axi_read(CTRL_ADDR, rd, rs);
    chk(rd, 32'h00000053); // default with lock and pin high
    chk(32'(pll_free_run), 32'h0);
    meas(p);
    chk(32'(p), 32'h8);
  endtask

  task automatic t_readonly();
    logic [1:0] r;
    axi_write(CTRL_ADDR, 8'h00, 4'hf, r); // reserved written zero
    axi_read(CTRL_ADDR, rd, rs);
    chk(rd, 32'h00000050); // lock and reserved keep their value
    pll_tracking        <= 1'b0;
    external_access_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    axi_read(CTRL_ADDR, rd, rs);
    chk(rd, 32'h00000010); // lock clear, latched pin kept
    chk(32'(pll_free_run), 32'h1);
    axi_write(CTRL_ADDR, 8'h07, 4'h0, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_read(CTRL_ADDR, rd, rs);
    chk(rd, 32'h00000010); // no lane, no store
    pll_tracking <= 1'b1;
  endtask

  task automatic t_errors();
    logic [1:0] r;
    axi_write(12'h100, 8'hff, 4'hf, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_read(12'h100, rd, rs);
    chk({rd[29:0], rs}, 32'(RESP_SLVERR));
    axi_write(TIMER_ADDR, 8'h55, 4'hf, r);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask

  task automatic t_osc();
    logic [1:0]  r;
    logic [31:0] t0;
    axi_write(CTRL_ADDR, 8'h83, 4'hf, r);
    power_down   <= 1'b1;
    pll_tracking <= 1'b0;
    axi_read(TIMER_ADDR, t0, rs);
    ticks(5);
    axi_read(TIMER_ADDR, rd, rs);
    chk(rd, t0); // halted oscillator, timer frozen
    chk(32'(interval_timer), t0);
    chk(32'(crystal_osc_running), 32'h0);
    axi_write(CTRL_ADDR, 8'h03, 4'hf, r);
    ticks(5);
    axi_read(TIMER_ADDR, rd, rs);
    chk(rd, t0 + 32'h5); // counting through power-down
    chk(32'(interval_timer), t0 + 32'h5);
    chk(32'(crystal_osc_running), 32'h1);
    power_down   <= 1'b0;
    pll_tracking <= 1'b1;
    do axi_read(CTRL_ADDR, rd, rs); while (rd[LOCK_BIT] !== 1'b1);
    chk(32'(rd[LOCK_BIT]), 32'h1);
  endtask

  task automatic t_divider();
    logic [1:0] r;
    int         p;
    for (int d = 0; d < 8; d++) begin
      axi_write(CTRL_ADDR, 8'(d), 4'hf, r);
      meas(p);
      chk(32'(p), 32'(1 << d));
    end
  endtask

  task automatic t_fast();
    logic [1:0] r;
    int         p;
    axi_write(CTRL_ADDR, 8'h0d, 4'hf, r);
    irq_in_service <= 1'b1;
    meas(p);
    chk(32'(p), 32'h1);
    irq_in_service <= 1'b0;
    meas(p);
    chk(32'(p), 32'h20);
    axi_write(CTRL_ADDR, 8'h05, 4'hf, r);
    irq_in_service <= 1'b1;
    meas(p);
    chk(32'(p), 32'h20);
    irq_in_service <= 1'b0;
  endtask

  task automatic t_rereset();
    int p;
    do_reset();
    axi_read(CTRL_ADDR, rd, rs);
    chk(rd, 32'h00000043); // pin low caught again
    meas(p);
    chk(32'(p), 32'h8);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {power_down, xtal_tick, irq_in_service} = 3'h0;
    pll_tracking = 1'b1;
    external_access_pin = 1'b1;
    do_reset();
    t_reset();
    t_readonly();
    t_errors();
    t_osc();
    t_divider();
    t_fast();
    t_rereset();
    close_out();
  end
endmodule

`default_nettype wire
